// >>> logic/hand_motor_property_feedback.sv
// Property set, supervision and realtime byte exchange for one hand motor.
// Assumes one clock, motor inputs synchronous to it, and a host that initializes first.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "hand_motor_cfg.svh"
module hand_motor_property_feedback #(
  parameter bit IS_SPREAD = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`HM_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire hand_motor_pkg::motion_cmd_s motionCmd,
  input wire logic motionActive,
  input wire logic motionOpening,
  input wire logic [15:0] motorPos,
  input wire logic signed [15:0] motorVel,
  input wire logic signed [15:0] motorAccel,
  input wire logic [7:0] strainRaw,
  input wire logic gaugeFitted,
  input wire logic [7:0] analogIn,
  input wire logic [14:0] statusCodes,
  input wire logic [31:0] travelRestore,
  input wire logic travelRestoreValid,
  input wire logic fbRequest,
  input wire logic ctrlStart,
  input wire logic ctrlValid,
  input wire logic [7:0] ctrlByte,
  output logic [15:0] targetPos,
  output logic targetValid,
  output logic [11:0] speedLimit,
  output logic motorHalt,
  output logic breakawayFlag,
  output logic [31:0] travelKilocounts,
  output logic [7:0] fbByte,
  output logic fbValid,
  output logic fbLast,
  output logic signed [15:0] ctrlVelocity,
  output logic [7:0] ctrlGain,
  output logic [15:0] ctrlPosRef,
  output logic ctrlDone
);
  localparam logic [15:0] DEST_RST = IS_SPREAD ? `HM_DEF_DEST_SPREAD : `HM_DEF_DEST_FINGER;
  localparam logic [15:0] INCR_RST = IS_SPREAD ? `HM_DEF_INCR_SPREAD : `HM_DEF_INCR_FINGER;
  localparam logic [11:0] SPEED_RST = IS_SPREAD ? `HM_SPEED_SPREAD : `HM_SPEED_FINGER;

  logic rstSync1, rstn;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1 <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstn <= rstSync1;
    end
  end

  // Property registers.
  logic [14:0] brkThresh_q, brkThresh_d;
  logic brkHalt_q, brkHalt_d;
  logic [15:0] defDest_q, defDest_d, defIncr_q, defIncr_d;
  logic [8:0] strUpper_q, strUpper_d, strLower_q, strLower_d;
  logic [11:0] openSpeed_q, openSpeed_d, closeSpeed_q, closeSpeed_d;
  logic [8:0] rtEn_q, rtEn_d;
  logic [7:0] velScale_q, velScale_d, velDiv_q, velDiv_d, deltaDiv_q, deltaDiv_d;
  logic [31:0] rdata_q, rdata_d;

  function automatic logic [11:0] clampSpeed(input logic [31:0] v);
    if (v < 32'(`HM_SPEED_MIN)) clampSpeed = `HM_SPEED_MIN;
    else if (v > 32'(`HM_SPEED_MAX)) clampSpeed = `HM_SPEED_MAX;
    else clampSpeed = v[11:0];
  endfunction : clampSpeed

  // Supervision state.
  logic brkFlag_q, brkFlag_d;
  logic [15:0] brkPos_q, brkPos_d;
  logic halt_q, halt_d;
  logic [15:0] target_q, target_d;
  logic targetValid_q, targetValid_d;
  logic [11:0] speed_q, speed_d;
  logic [14:0] status_q, status_d;
  logic [7:0] strain_q, strain_d;
  logic [15:0] prevPos_q, prevPos_d;
  logic [9:0] travelFrac_q, travelFrac_d;
  logic [31:0] travel_q, travel_d;

  logic [15:0] absAccel;
  logic brkEvent, brkClear, strainStop;
  assign absAccel = motorAccel[15] ? 16'(-motorAccel) : motorAccel;
  assign brkEvent = !IS_SPREAD && motionActive && (absAccel > {1'b0, brkThresh_q});
  assign brkClear = motionCmd.open || motionCmd.torqueOpen || motionCmd.init;
  assign strainStop = motionActive && (
      ((strUpper_q < `HM_STR_DISABLE_LO) && ({1'b0, strain_q} > strUpper_q)) ||
      ((strLower_q < `HM_STR_DISABLE_LO) && ({1'b0, strain_q} < strLower_q)));

  always_comb begin
    brkThresh_d = brkThresh_q;
    brkHalt_d = brkHalt_q;
    defDest_d = defDest_q;
    defIncr_d = defIncr_q;
    strUpper_d = strUpper_q;
    strLower_d = strLower_q;
    openSpeed_d = openSpeed_q;
    closeSpeed_d = closeSpeed_q;
    rtEn_d = rtEn_q;
    velScale_d = velScale_q;
    velDiv_d = velDiv_q;
    deltaDiv_d = deltaDiv_q;
    rdata_d = 32'h0000_0000;
    if (regWrite) begin
      if (regAddr == `HM_OFF_BRK_THRESH) begin
        brkThresh_d = (regWdata > 32'(`HM_BRK_THRESH_MAX)) ? `HM_BRK_THRESH_MAX : regWdata[14:0];
      end else if (regAddr == `HM_OFF_BRK_HALT) begin
        brkHalt_d = regWdata[0] && !IS_SPREAD;
      end else if (regAddr == `HM_OFF_DEF_DEST) begin
        defDest_d = regWdata[15:0];
      end else if (regAddr == `HM_OFF_DEF_INCR) begin
        defIncr_d = regWdata[15:0];
      end else if (regAddr == `HM_OFF_STR_UPPER || regAddr == `HM_OFF_STR_UPPER_ALIAS) begin
        strUpper_d = (regWdata > 32'(`HM_STR_LIMIT_MAX)) ? `HM_STR_LIMIT_MAX : regWdata[8:0];
      end else if (regAddr == `HM_OFF_STR_LOWER) begin
        strLower_d = (regWdata > 32'(`HM_STR_LIMIT_MAX)) ? `HM_STR_LIMIT_MAX : regWdata[8:0];
      end else if (regAddr == `HM_OFF_OPEN_SPEED) begin
        openSpeed_d = clampSpeed(regWdata);
      end else if (regAddr == `HM_OFF_CLOSE_SPEED) begin
        closeSpeed_d = clampSpeed(regWdata);
      end else if (regAddr == `HM_OFF_RT_ENABLES) begin
        rtEn_d = regWdata[8:0];
      end else if (regAddr == `HM_OFF_CTRL_VEL_SCALE) begin
        velScale_d = regWdata[7:0];
      end else if (regAddr == `HM_OFF_FB_VEL_DIV) begin
        velDiv_d = regWdata[7:0];
      end else if (regAddr == `HM_OFF_FB_DELTA_DIV) begin
        deltaDiv_d = regWdata[7:0];
      end
    end
    if (regRead) begin
      if (regAddr == `HM_OFF_BRK_THRESH) rdata_d = {17'h0, brkThresh_q};
      else if (regAddr == `HM_OFF_BRK_HALT) rdata_d = {31'h0, brkHalt_q};
      else if (regAddr == `HM_OFF_DEF_DEST) rdata_d = {16'h0, defDest_q};
      else if (regAddr == `HM_OFF_DEF_INCR) rdata_d = {16'h0, defIncr_q};
      else if (regAddr == `HM_OFF_STR_UPPER || regAddr == `HM_OFF_STR_UPPER_ALIAS) begin
        rdata_d = {23'h0, strUpper_q};
      end else if (regAddr == `HM_OFF_STR_LOWER) rdata_d = {23'h0, strLower_q};
      else if (regAddr == `HM_OFF_OPEN_SPEED) rdata_d = {20'h0, openSpeed_q};
      else if (regAddr == `HM_OFF_CLOSE_SPEED) rdata_d = {20'h0, closeSpeed_q};
      else if (regAddr == `HM_OFF_BRK_FLAG) rdata_d = {31'h0, brkFlag_q};
      else if (regAddr == `HM_OFF_BRK_POS) rdata_d = {16'h0, brkPos_q};
      else if (regAddr == `HM_OFF_TRAVEL) rdata_d = travel_q;
      else if (regAddr == `HM_OFF_STATUS) rdata_d = {17'h0, status_q};
      else if (regAddr == `HM_OFF_STRAIN) rdata_d = {24'h0, strain_q};
      else if (regAddr == `HM_OFF_RT_ENABLES) rdata_d = {23'h0, rtEn_q};
      else if (regAddr == `HM_OFF_CTRL_VEL_SCALE) rdata_d = {24'h0, velScale_q};
      else if (regAddr == `HM_OFF_FB_VEL_DIV) rdata_d = {24'h0, velDiv_q};
      else if (regAddr == `HM_OFF_FB_DELTA_DIV) rdata_d = {24'h0, deltaDiv_q};
    end
  end

  logic [15:0] posStep;
  logic [9:0] stepRem;
  assign posStep = (motorPos >= prevPos_q) ? 16'(motorPos - prevPos_q) : 16'(prevPos_q - motorPos);
  assign stepRem = 10'(posStep % 16'(`HM_TRAVEL_UNIT));

  always_comb begin
    // A breakaway in the same cycle as a clearing command keeps the flag set.
    brkFlag_d = brkEvent ? 1'b1 : (brkClear ? 1'b0 : brkFlag_q);
    brkPos_d = brkEvent ? motorPos : (brkClear ? 16'h0000 : brkPos_q);
    halt_d = (brkEvent && brkHalt_q) || strainStop;
    target_d = target_q;
    targetValid_d = 1'b0;
    if (motionCmd.move) begin
      target_d = motionCmd.hasArg ? motionCmd.arg : defDest_q;
      targetValid_d = 1'b1;
    end else if (motionCmd.incOpen) begin
      target_d = 16'(motorPos - (motionCmd.hasArg ? motionCmd.arg : defIncr_q));
      targetValid_d = 1'b1;
    end else if (motionCmd.incClose) begin
      target_d = 16'(motorPos + (motionCmd.hasArg ? motionCmd.arg : defIncr_q));
      targetValid_d = 1'b1;
    end
    speed_d = motionOpening ? openSpeed_q : closeSpeed_q;
    status_d = statusCodes;
    strain_d = gaugeFitted ? strainRaw : `HM_STRAIN_ABSENT;
    prevPos_d = motorPos;
    // Travel is counted per cycle; the remainder below one kilocount carries over.
    travelFrac_d = 10'(travelFrac_q + stepRem);
    travel_d = 32'(travel_q + 32'(posStep / 16'(`HM_TRAVEL_UNIT)));
    if (({1'b0, travelFrac_q} + {1'b0, stepRem}) >= 11'(`HM_TRAVEL_UNIT)) begin
      travelFrac_d = 10'(travelFrac_q + stepRem - `HM_TRAVEL_UNIT);
      travel_d = 32'(travel_d + 32'h1);
    end
    if (travelRestoreValid) travel_d = travelRestore;
  end

  // Realtime feedback serializer.
  hand_motor_pkg::fb_field_e fbField_q, fbField_d;
  logic [8:1] fbWant;
  logic [15:0] lastRep_q, lastRep_d;
  logic [7:0] fbByte_q, fbByte_d;
  logic fbValid_q, fbValid_d, fbLast_q, fbLast_d;
  logic signed [16:0] deltaRaw, deltaQuot, velQuot;
  logic signed [7:0] deltaByte, velByte;
  logic [3:0] fbNext;

  assign fbWant = {rtEn_q[`HM_EN_FB_BRK_POS], rtEn_q[`HM_EN_FB_BRK_POS],
                   rtEn_q[`HM_EN_FB_ANALOG], rtEn_q[`HM_EN_FB_STRAIN],
                   rtEn_q[`HM_EN_FB_VEL], rtEn_q[`HM_EN_FB_DELTA],
                   rtEn_q[`HM_EN_FB_POS], rtEn_q[`HM_EN_FB_POS]};
  assign deltaRaw = 17'($signed({1'b0, motorPos}) - $signed({1'b0, lastRep_q}));
  // A zero divisor is treated as one so the byte stays defined.
  assign deltaQuot = deltaRaw / $signed({9'h000, (deltaDiv_q == 8'h00) ? 8'h01 : deltaDiv_q});
  assign velQuot = 17'(motorVel) / $signed({9'h000, (velDiv_q == 8'h00) ? 8'h01 : velDiv_q});
  assign deltaByte = (deltaQuot > 17'sd127) ? 8'sd127 :
                     (deltaQuot < -17'sd128) ? -8'sd128 : deltaQuot[7:0];
  assign velByte = (velQuot > 17'sd127) ? 8'sd127 :
                   (velQuot < -17'sd128) ? -8'sd128 : velQuot[7:0];

  always_comb begin
    fbNext = 4'h0;
    for (int i = 8; i >= 1; i--) begin
      if (fbWant[i] && (4'(i) > 4'(fbField_q))) fbNext = 4'(i);
    end
  end

  always_comb begin
    fbField_d = fbField_q;
    fbByte_d = 8'h00;
    fbValid_d = 1'b0;
    fbLast_d = 1'b0;
    lastRep_d = lastRep_q;
    if (fbField_q == hand_motor_pkg::FB_IDLE) begin
      if (fbRequest) fbField_d = hand_motor_pkg::fb_field_e'(fbNext);
    end else begin
      fbValid_d = 1'b1;
      fbLast_d = (fbNext == 4'h0);
      fbField_d = hand_motor_pkg::fb_field_e'(fbNext);
      case (fbField_q)
        hand_motor_pkg::FB_POS_HI: fbByte_d = motorPos[15:8];
        hand_motor_pkg::FB_POS_LO: fbByte_d = motorPos[7:0];
        hand_motor_pkg::FB_DELTA: begin
          fbByte_d = deltaByte;
          lastRep_d = 16'(lastRep_q + 16'(16'(deltaByte) * 16'($signed({1'b0, deltaDiv_q}))));
        end
        hand_motor_pkg::FB_VEL: fbByte_d = velByte;
        hand_motor_pkg::FB_STRAIN: fbByte_d = strain_q;
        hand_motor_pkg::FB_ANALOG: fbByte_d = analogIn;
        hand_motor_pkg::FB_BRK_HI: fbByte_d = brkPos_q[15:8];
        hand_motor_pkg::FB_BRK_LO: fbByte_d = brkPos_q[7:0];
        default: fbByte_d = 8'h00;
      endcase
    end
    if (motionCmd.init) lastRep_d = 16'h0000;
  end

  // Realtime control block parser.
  hand_motor_pkg::ct_field_e ctField_q, ctField_d;
  logic [4:1] ctWant;
  logic [2:0] ctNext, ctFirst;
  logic [7:0] ctVelByte_q, ctVelByte_d, ctTqHi_q, ctTqHi_d;
  logic signed [15:0] ctrlVel_q, ctrlVel_d;
  logic [7:0] ctrlGain_q, ctrlGain_d;
  logic [15:0] posRef_q, posRef_d;
  logic ctrlDone_q, ctrlDone_d;

  assign ctWant = {rtEn_q[`HM_EN_CTRL_TORQUE], rtEn_q[`HM_EN_CTRL_TORQUE],
                   rtEn_q[`HM_EN_CTRL_GAIN], rtEn_q[`HM_EN_CTRL_VEL]};
  always_comb begin
    ctNext = 3'h0;
    ctFirst = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      if (ctWant[i] && (3'(i) > 3'(ctField_q))) ctNext = 3'(i);
      if (ctWant[i]) ctFirst = 3'(i);
    end
  end

  always_comb begin
    ctField_d = ctField_q;
    ctVelByte_d = ctVelByte_q;
    ctTqHi_d = ctTqHi_q;
    ctrlVel_d = ctrlVel_q;
    ctrlGain_d = ctrlGain_q;
    posRef_d = posRef_q;
    ctrlDone_d = 1'b0;
    if (ctrlStart) begin
      ctField_d = hand_motor_pkg::ct_field_e'(ctFirst);
    end else if (ctrlValid && ctField_q != hand_motor_pkg::CT_IDLE) begin
      ctField_d = hand_motor_pkg::ct_field_e'(ctNext);
      ctrlDone_d = (ctNext == 3'h0);
      case (ctField_q)
        hand_motor_pkg::CT_VEL: begin
          ctrlVel_d = 16'(16'($signed(ctrlByte)) * 16'($signed({1'b0, velScale_q})));
        end
        hand_motor_pkg::CT_GAIN: ctrlGain_d = ctrlByte;
        hand_motor_pkg::CT_TQ_HI: ctTqHi_d = ctrlByte;
        hand_motor_pkg::CT_TQ_LO: posRef_d = 16'(motorPos + {ctTqHi_q, ctrlByte});
        default: ctrlDone_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brkThresh_q <= `HM_BRK_THRESH_RST;
      brkHalt_q <= 1'b0;
      defDest_q <= DEST_RST;
      defIncr_q <= INCR_RST;
      strUpper_q <= `HM_STR_LIMIT_RST;
      strLower_q <= `HM_STR_LIMIT_RST;
      openSpeed_q <= SPEED_RST;
      closeSpeed_q <= SPEED_RST;
      rtEn_q <= `HM_RT_ENABLES_RST;
      velScale_q <= `HM_COEF_RST;
      velDiv_q <= `HM_COEF_RST;
      deltaDiv_q <= `HM_COEF_RST;
      rdata_q <= 32'h0000_0000;
      brkFlag_q <= 1'b0;
      brkPos_q <= 16'h0000;
      halt_q <= 1'b0;
      target_q <= 16'h0000;
      targetValid_q <= 1'b0;
      speed_q <= SPEED_RST;
      status_q <= 15'h0000;
      strain_q <= `HM_STRAIN_ABSENT;
      prevPos_q <= 16'h0000;
      travelFrac_q <= 10'h000;
      travel_q <= 32'h0000_0000;
      fbField_q <= hand_motor_pkg::FB_IDLE;
      lastRep_q <= 16'h0000;
      fbByte_q <= 8'h00;
      fbValid_q <= 1'b0;
      fbLast_q <= 1'b0;
      ctField_q <= hand_motor_pkg::CT_IDLE;
      ctVelByte_q <= 8'h00;
      ctTqHi_q <= 8'h00;
      ctrlVel_q <= 16'sh0000;
      ctrlGain_q <= 8'h00;
      posRef_q <= 16'h0000;
      ctrlDone_q <= 1'b0;
    end else begin
      brkThresh_q <= brkThresh_d;
      brkHalt_q <= brkHalt_d;
      defDest_q <= defDest_d;
      defIncr_q <= defIncr_d;
      strUpper_q <= strUpper_d;
      strLower_q <= strLower_d;
      openSpeed_q <= openSpeed_d;
      closeSpeed_q <= closeSpeed_d;
      rtEn_q <= rtEn_d;
      velScale_q <= velScale_d;
      velDiv_q <= velDiv_d;
      deltaDiv_q <= deltaDiv_d;
      rdata_q <= rdata_d;
      brkFlag_q <= brkFlag_d;
      brkPos_q <= brkPos_d;
      halt_q <= halt_d;
      target_q <= target_d;
      targetValid_q <= targetValid_d;
      speed_q <= speed_d;
      status_q <= status_d;
      strain_q <= strain_d;
      prevPos_q <= prevPos_d;
      travelFrac_q <= travelFrac_d;
      travel_q <= travel_d;
      fbField_q <= fbField_d;
      lastRep_q <= lastRep_d;
      fbByte_q <= fbByte_d;
      fbValid_q <= fbValid_d;
      fbLast_q <= fbLast_d;
      ctField_q <= ctField_d;
      ctVelByte_q <= ctVelByte_d;
      ctTqHi_q <= ctTqHi_d;
      ctrlVel_q <= ctrlVel_d;
      ctrlGain_q <= ctrlGain_d;
      posRef_q <= posRef_d;
      ctrlDone_q <= ctrlDone_d;
    end
  end

  assign regRdata = rdata_q;
  assign targetPos = target_q;
  assign targetValid = targetValid_q;
  assign speedLimit = speed_q;
  assign motorHalt = halt_q;
  assign breakawayFlag = brkFlag_q;
  assign travelKilocounts = travel_q;
  assign fbByte = fbByte_q;
  assign fbValid = fbValid_q;
  assign fbLast = fbLast_q;
  assign ctrlVelocity = ctrlVel_q;
  assign ctrlGain = ctrlGain_q;
  assign ctrlPosRef = posRef_q;
  assign ctrlDone = ctrlDone_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence brkSeen;
    brkEvent;
  endsequence
  sequence posReq;
    fbRequest && fbField_q == hand_motor_pkg::FB_IDLE && fbWant[1];
  endsequence

  chk_brk_sets: assert property (brkSeen |=> brkFlag_q && brkPos_q == $past(motorPos))
    else $error("Breakaway did not set flag and position.");
  chk_brk_halt: assert property (brkSeen and brkHalt_q |=> motorHalt)
    else $error("Breakaway did not halt the motor.");
  chk_move_default: assert property (motionCmd.move && !motionCmd.hasArg
      |=> targetValid && targetPos == $past(defDest_q))
    else $error("Move without argument missed default destination.");
  chk_incr_default: assert property (motionCmd.incClose && !motionCmd.move && !motionCmd.incOpen
      && !motionCmd.hasArg
      |=> targetPos == 16'($past(motorPos) + $past(defIncr_q)))
    else $error("Increment without argument missed default step.");
  chk_strain_disable: assert property (strUpper_q >= `HM_STR_DISABLE_LO
      && strLower_q >= `HM_STR_DISABLE_LO && !brkEvent |=> !motorHalt)
    else $error("Disabled strain check halted the motor.");
  chk_speed_pick: assert property (motionOpening |=> speedLimit == $past(openSpeed_q))
    else $error("Open speed limit not applied.");
  chk_brk_clear: assert property (brkClear && !brkEvent |=> !brkFlag_q && brkPos_q == 16'h0)
    else $error("Clearing command left breakaway state.");
  chk_strain_absent: assert property (!gaugeFitted |=> strain_q == `HM_STRAIN_ABSENT)
    else $error("Missing gauge did not read full scale.");
  chk_pos_order: assert property (posReq |=> ##1 fbValid && fbByte == $past(motorPos[15:8], 1))
    else $error("Position feedback not sent high byte first.");
  chk_fb_end: assert property (fbLast |-> fbValid ##1 !fbValid)
    else $error("Feedback stream continued past its last byte.");
endmodule : hand_motor_property_feedback

// >>> logic/hand_motor_cfg.svh
// Register offsets, field positions, reset values and limits of one motor's property block.
// Assumes a 32-bit register port with byte addresses in steps of four.
`ifndef HAND_MOTOR_CFG_SVH
`define HAND_MOTOR_CFG_SVH
`define HM_ADDR_W 8
`define HM_OFF_BRK_THRESH 8'h00
`define HM_OFF_BRK_HALT 8'h04
`define HM_OFF_DEF_DEST 8'h08
`define HM_OFF_DEF_INCR 8'h0C
`define HM_OFF_STR_UPPER 8'h10
`define HM_OFF_STR_UPPER_ALIAS 8'h14
`define HM_OFF_STR_LOWER 8'h18
`define HM_OFF_OPEN_SPEED 8'h1C
`define HM_OFF_CLOSE_SPEED 8'h20
`define HM_OFF_BRK_FLAG 8'h24
`define HM_OFF_BRK_POS 8'h28
`define HM_OFF_TRAVEL 8'h2C
`define HM_OFF_STATUS 8'h30
`define HM_OFF_STRAIN 8'h34
`define HM_OFF_RT_ENABLES 8'h38
`define HM_OFF_CTRL_VEL_SCALE 8'h3C
`define HM_OFF_FB_VEL_DIV 8'h40
`define HM_OFF_FB_DELTA_DIV 8'h44
// Bit positions inside the realtime enable register.
`define HM_EN_CTRL_VEL 0
`define HM_EN_CTRL_GAIN 1
`define HM_EN_CTRL_TORQUE 2
`define HM_EN_FB_ANALOG 3
`define HM_EN_FB_BRK_POS 4
`define HM_EN_FB_VEL 5
`define HM_EN_FB_STRAIN 6
`define HM_EN_FB_POS 7
`define HM_EN_FB_DELTA 8
`define HM_RT_ENABLES_RST 9'h1E3
`define HM_BRK_THRESH_RST 15'h05DC
`define HM_BRK_THRESH_MAX 15'h4E20
`define HM_DEF_DEST_FINGER 16'h2134
`define HM_DEF_DEST_SPREAD 16'h0627
`define HM_DEF_INCR_FINGER 16'h06A4
`define HM_DEF_INCR_SPREAD 16'h013B
`define HM_STR_LIMIT_RST 9'h100
`define HM_STR_DISABLE_LO 9'h0FF
`define HM_STR_LIMIT_MAX 9'h100
`define HM_SPEED_FINGER 12'h064
`define HM_SPEED_SPREAD 12'h03C
`define HM_SPEED_MIN 12'h010
`define HM_SPEED_MAX 12'hFF0
`define HM_COEF_RST 8'h01
`define HM_TRAVEL_UNIT 10'h3E8
`define HM_TICKLETS_PER_MS 307
`define HM_STRAIN_ABSENT 8'hFF
`endif

// >>> logic/hand_motor_pkg.sv
// Types shared by the motor property and feedback block.
// Assumes the constants of hand_motor_cfg.svh for all figures.
package hand_motor_pkg;
  typedef struct packed {
    logic open;
    logic torqueOpen;
    logic init;
    logic move;
    logic incOpen;
    logic incClose;
    logic hasArg;
    logic [15:0] arg;
  } motion_cmd_s;
  typedef enum logic [3:0] {
    FB_IDLE, FB_POS_HI, FB_POS_LO, FB_DELTA, FB_VEL, FB_STRAIN, FB_ANALOG, FB_BRK_HI, FB_BRK_LO
  } fb_field_e;
  typedef enum logic [2:0] {CT_IDLE, CT_VEL, CT_GAIN, CT_TQ_HI, CT_TQ_LO} ct_field_e;
endpackage : hand_motor_pkg

// >>> sim/rt_host_model.sv
// Host side of the realtime exchange: sends control blocks and gathers feedback blocks.
// Assumes the motor block's realtime ports and the same clock.
`timescale 1ns/10ps
module rt_host_model (
  input wire logic clk,
  output logic ctrlStart,
  output logic ctrlValid,
  output logic [7:0] ctrlByte,
  output logic fbRequest,
  input wire logic [7:0] fbByte,
  input wire logic fbValid,
  input wire logic fbLast
);
  logic [7:0] fb[$];
  initial begin
    ctrlStart = 1'b0;
    ctrlValid = 1'b0;
    ctrlByte = 8'hA5;
    fbRequest = 1'b0;
  end
  task automatic send_ctrl(input logic [7:0] v, input logic [7:0] g);
    @(posedge clk);
    ctrlStart <= 1'b1;
    @(posedge clk);
    ctrlStart <= 1'b0;
    ctrlValid <= 1'b1;
    ctrlByte <= v;
    @(posedge clk);
    ctrlByte <= g;
    @(posedge clk);
    ctrlValid <= 1'b0;
    // An idle byte lane never keeps the last value.
    ctrlByte <= ~g;
    @(posedge clk);
    #1;
  endtask : send_ctrl
  task automatic fetch_fb();
    fb.delete();
    @(posedge clk);
    fbRequest <= 1'b1;
    @(posedge clk);
    fbRequest <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (fbValid === 1'b1) fb.push_back(fbByte);
      if (fbLast === 1'b1) break;
    end
  endtask : fetch_fb
endmodule : rt_host_model

// >>> sim/tb_hand_motor_property_feedback.sv
// Self-checking bench for one finger motor's property, supervision and realtime logic.
// Assumes the host model drives the realtime ports.
`timescale 1ns/10ps
module tb_hand_motor_property_feedback;
  logic clk, resetn, regWrite, regRead, motionActive, motionOpening, gaugeFitted;
  logic [7:0] regAddr, strainRaw, fbByte, ctrlByte, ctrlGain;
  logic [31:0] regWdata, regRdata, travelKilocounts;
  logic [15:0] motorPos, targetPos, ctrlPosRef;
  logic signed [15:0] motorVel, motorAccel, ctrlVelocity;
  logic [14:0] statusCodes;
  logic [11:0] speedLimit;
  logic targetValid, motorHalt, breakawayFlag, fbValid, fbLast, ctrlDone;
  logic fbRequest, ctrlStart, ctrlValid;
  hand_motor_pkg::motion_cmd_s cmd;
  int error_cnt = 0, total_checks = 0, cycles = 0;
  logic [7:0] addrs[9] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h38, 8'h3C, 8'h48};
  logic [31:0] rstv[9] = '{32'h5DC, 32'h2134, 32'h6A4, 32'h100, 32'h100, 32'h64, 32'h1E3,
    32'h1, 32'h0};
  logic [7:0] fbExp[5] = '{8'h04, 8'hD2, 8'h7F, 8'h03, 8'h55};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  hand_motor_property_feedback #(.IS_SPREAD(1'b0)) DUT (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .motionCmd(cmd),
    .motionActive(motionActive), .motionOpening(motionOpening), .motorPos(motorPos),
    .motorVel(motorVel), .motorAccel(motorAccel), .strainRaw(strainRaw),
    .gaugeFitted(gaugeFitted), .analogIn(8'h00), .statusCodes(statusCodes),
    .travelRestore(32'h0), .travelRestoreValid(1'b0), .fbRequest(fbRequest),
    .ctrlStart(ctrlStart), .ctrlValid(ctrlValid), .ctrlByte(ctrlByte),
    .targetPos(targetPos), .targetValid(targetValid), .speedLimit(speedLimit),
    .motorHalt(motorHalt), .breakawayFlag(breakawayFlag),
    .travelKilocounts(travelKilocounts), .fbByte(fbByte), .fbValid(fbValid),
    .fbLast(fbLast), .ctrlVelocity(ctrlVelocity), .ctrlGain(ctrlGain),
    .ctrlPosRef(ctrlPosRef), .ctrlDone(ctrlDone));
  rt_host_model host (.clk(clk), .ctrlStart(ctrlStart), .ctrlValid(ctrlValid),
    .ctrlByte(ctrlByte), .fbRequest(fbRequest), .fbByte(fbByte), .fbValid(fbValid),
    .fbLast(fbLast));
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask : rd
  task automatic pulse(input logic [22:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    resetn = 1'b0;
    {regWrite, regRead, regAddr, regWdata, cmd, motionActive, motionOpening} = '0;
    {motorAccel, statusCodes} = '0;
    motorPos = 16'h04D2;
    motorVel = 16'sh0003;
    strainRaw = 8'h55;
    gaugeFitted = 1'b1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle(3);
    chk(speedLimit, 32'h64);
    for (int i = 0; i < 9; i++) rd(addrs[i], rstv[i]);
    rd(8'h2C, 32'h1);
    wr(8'h24, 32'h1);
    rd(8'h24, 32'h0);
    pulse(23'h100000);
    pulse(23'h080000);
    chk(targetValid, 32'h1);
    chk(targetPos, 32'h2134);
    wr(8'h04, 32'h1);
    motionActive <= 1'b1;
    motorAccel <= 16'sh05DC;
    settle(3);
    chk(breakawayFlag, 32'h0);
    motorAccel <= 16'sh05DD;
    settle(2);
    chk(breakawayFlag, 32'h1);
    chk(motorHalt, 32'h1);
    motorAccel <= '0;
    motionActive <= 1'b0;
    rd(8'h28, 32'h4D2);
    pulse(23'h400000);
    chk(breakawayFlag, 32'h0);
    rd(8'h28, 32'h0);
    wr(8'h10, 32'h64);
    strainRaw <= 8'h65;
    motionActive <= 1'b1;
    settle(3);
    chk(motorHalt, 32'h1);
    wr(8'h14, 32'hFF);
    settle(2);
    chk(motorHalt, 32'h0);
    wr(8'h18, 32'h32);
    strainRaw <= 8'h28;
    settle(3);
    chk(motorHalt, 32'h1);
    wr(8'h18, 32'h100);
    strainRaw <= 8'h55;
    wr(8'h1C, 32'hC8);
    wr(8'h20, 32'h12C);
    motionOpening <= 1'b1;
    settle(2);
    chk(speedLimit, 32'hC8);
    motionOpening <= 1'b0;
    settle(2);
    chk(speedLimit, 32'h12C);
    motionActive <= 1'b0;
    statusCodes <= 15'h4000;
    rd(8'h30, 32'h4000);
    gaugeFitted <= 1'b0;
    rd(8'h34, 32'hFF);
    gaugeFitted <= 1'b1;
    settle(2);
    host.fetch_fb();
    chk(host.fb.size(), 32'h5);
    for (int i = 0; i < 5; i++) chk(host.fb[i], fbExp[i]);
    host.send_ctrl(8'h05, 8'h22);
    chk(ctrlGain, 32'h22);
    chk(ctrlVelocity, 32'h5);
    give_verdict();
  end
endmodule : tb_hand_motor_property_feedback
